// ===== logic/lcam_pkg.sv
package lcam_pkg;
  // ==========================================================
  // Address space
  localparam int LCAM_AW = 16;
  localparam logic [15:0] LCAM_IO_BASE = 16'h0020;     // I/O location 0 in data space
  localparam logic [15:0] LCAM_IO_LAST = 16'h005F;     // Last of the 64 legacy I/O locations
  localparam logic [15:0] LCAM_EXT_LO = 16'h0060;      // Extended region start
  localparam logic [15:0] LCAM_EXT_HI = 16'h00FF;      // Extended region end
  localparam int LCAM_IO_AW = 6;                       // In/out operand width
  localparam logic [1:0] LCAM_SYNC_FILL = 2'h3;        // Edges until the fuse stages hold the pin

  // ==========================================================
  // Peripheral locations, chosen placement
  localparam logic [15:0] LCAM_BAUD0_ADDR = 16'h0040;  // Channel 0 baud high byte
  localparam logic [15:0] LCAM_BAUD1_ADDR = 16'h005C;  // Channel 1 baud high byte
  localparam logic [15:0] LCAM_PCHG_LO = 16'h0061;     // Pin-change control block
  localparam logic [15:0] LCAM_PCHG_HI = 16'h0063;
  localparam logic [15:0] LCAM_TMR2_LO = 16'h0088;     // Second wide timer block
  localparam logic [15:0] LCAM_TMR2_HI = 16'h008F;

  // ==========================================================
  // Interrupt vector table sizes
  localparam logic [4:0] LCAM_VEC_FULL = 5'h1C;        // Full table entry count
  localparam logic [4:0] LCAM_VEC_LEGACY = 5'h14;      // Predecessor table entry count
  localparam logic [4:0] LCAM_VEC_RESET = 5'h00;
  localparam logic [7:0] LCAM_OFS_RESET = 8'h00;
endpackage

// ===== logic/lcam_fuse_sample.sv
`timescale 1ns/100ps
module lcam_fuse_sample
  import lcam_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic fuse_pin,
  output logic fuse_q,
  output logic valid_q
);
  // ==========================================================
  // Three-stage synchroniser, then one capture after reset
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;
  logic fuse_d, valid_d;
  logic [1:0] fill_q, fill_d;

  // Capture only once the stages are filled and two and three agree, then freeze;
  // without the fill count the reset zeros would be captured as a false fuse value
  always_comb begin
    s1_d = fuse_pin;
    s2_d = s1_q;
    s3_d = s2_q;
    fuse_d = fuse_q;
    valid_d = valid_q;
    fill_d = fill_q;
    if (fill_q != LCAM_SYNC_FILL) begin
      fill_d = fill_q + 2'h1;
    end
    if (!valid_q && (fill_q == LCAM_SYNC_FILL) && (s2_q == s3_q)) begin
      fuse_d = s3_q;   // Held for the rest of the run
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      fuse_q <= 1'b0;
      valid_q <= 1'b0;
      fill_q <= 2'h0;
    end else if (clk_en) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      fuse_q <= fuse_d;
      valid_q <= valid_d;
      fill_q <= fill_d;
    end
  end
endmodule

// ===== logic/lcam_addr_map.sv
`timescale 1ns/100ps
module lcam_addr_map
  import lcam_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic legacy_mode_fuse,
  input wire logic acc_valid,
  input wire logic acc_io_op,
  input wire logic acc_write,
  input wire logic [15:0] acc_addr,
  output logic cfg_ready_q,
  output logic legacy_q,
  output logic hit_io_q,
  output logic hit_ext_q,
  output logic hit_ram_q,
  output logic hit_baud0_q,
  output logic hit_baud1_q,
  output logic hit_pchg_q,
  output logic hit_tmr2_q,
  output logic acc_write_q,
  output logic [7:0] periph_ofs_q,
  output logic [4:0] vec_count_q,
  output logic wdt_timed_seq_en_q,
  output logic rx_double_buf_en_q,
  output logic pchg_irq_en_q,
  output logic tmr2_en_q
);
  // ==========================================================
  // Helpers
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic fuse_s, fuse_ok;

  // Fuse held from its capture after reset onward
  lcam_fuse_sample u_fuse (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .fuse_pin(legacy_mode_fuse),
    .fuse_q(fuse_s),
    .valid_q(fuse_ok)
  );

  // ==========================================================
  // Feature gates
  logic cfg_ready_d, legacy_d;
  logic [4:0] vec_count_d;
  logic wdt_d, rxdb_d, pchg_en_d, tmr2_en_d;

  // Gates follow the captured fuse only, never the live pin
  always_comb begin
    cfg_ready_d = fuse_ok;
    legacy_d = fuse_ok & fuse_s;
    vec_count_d = LCAM_VEC_RESET;
    if (fuse_ok) begin
      vec_count_d = fuse_s ? LCAM_VEC_LEGACY : LCAM_VEC_FULL;
    end
    wdt_d = fuse_ok & ~fuse_s;
    rxdb_d = fuse_ok & ~fuse_s;
    pchg_en_d = fuse_ok & ~fuse_s;
    tmr2_en_d = fuse_ok & ~fuse_s;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg_ready_q <= 1'b0;
      legacy_q <= 1'b0;
      vec_count_q <= LCAM_VEC_RESET;
      wdt_timed_seq_en_q <= 1'b0;
      rx_double_buf_en_q <= 1'b0;
      pchg_irq_en_q <= 1'b0;
      tmr2_en_q <= 1'b0;
    end else if (clk_en) begin
      cfg_ready_q <= cfg_ready_d;
      legacy_q <= legacy_d;
      vec_count_q <= vec_count_d;
      wdt_timed_seq_en_q <= wdt_d;
      rx_double_buf_en_q <= rxdb_d;
      pchg_irq_en_q <= pchg_en_d;
      tmr2_en_q <= tmr2_en_d;
    end
  end

  // ==========================================================
  // Access decode
  logic [15:0] daddr;
  logic hit_io_d, hit_ext_d, hit_ram_d, hit_b0_d, hit_b1_d, hit_pc_d, hit_t2_d, wr_d;
  logic [7:0] ofs_d;
  logic ext_win;

  // In/out operands are I/O numbers; lift them into data space first
  always_comb begin
    daddr = acc_io_op ? (LCAM_IO_BASE + {10'h000, acc_addr[LCAM_IO_AW-1:0]}) : acc_addr;
    ext_win = acc_valid && fuse_ok && !acc_io_op &&
              in_range(daddr, LCAM_EXT_LO, LCAM_EXT_HI);
    hit_io_d = acc_valid && fuse_ok && in_range(daddr, LCAM_IO_BASE, LCAM_IO_LAST);
    hit_ext_d = ext_win && !fuse_s;
    hit_ram_d = ext_win && fuse_s;                   // Extended region turns RAM
    hit_b0_d = acc_valid && fuse_ok && (daddr == LCAM_BAUD0_ADDR);
    hit_b1_d = acc_valid && fuse_ok && (daddr == LCAM_BAUD1_ADDR);
    hit_pc_d = hit_ext_d && in_range(daddr, LCAM_PCHG_LO, LCAM_PCHG_HI);
    hit_t2_d = hit_ext_d && in_range(daddr, LCAM_TMR2_LO, LCAM_TMR2_HI);
    wr_d = acc_valid && fuse_ok && acc_write;
    ofs_d = LCAM_OFS_RESET;
    if (acc_valid && fuse_ok) begin
      ofs_d = daddr[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hit_io_q <= 1'b0;
      hit_ext_q <= 1'b0;
      hit_ram_q <= 1'b0;
      hit_baud0_q <= 1'b0;
      hit_baud1_q <= 1'b0;
      hit_pchg_q <= 1'b0;
      hit_tmr2_q <= 1'b0;
      acc_write_q <= 1'b0;
      periph_ofs_q <= LCAM_OFS_RESET;
    end else if (clk_en) begin
      hit_io_q <= hit_io_d;
      hit_ext_q <= hit_ext_d;
      hit_ram_q <= hit_ram_d;
      hit_baud0_q <= hit_b0_d;
      hit_baud1_q <= hit_b1_d;
      hit_pchg_q <= hit_pc_d;
      hit_tmr2_q <= hit_t2_d;
      acc_write_q <= wr_d;
      periph_ofs_q <= ofs_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Update flag, registered so the checks see last cycle's enable and reset
  logic upd;
  always_ff @(posedge mclk) begin
    upd <= clk_en && reset_n;
  end

  chk_ext_no_io: assert property (upd && $past(acc_io_op) |-> !hit_ext_q && !hit_ram_q)
    else $error("extended region hit by in/out");
  chk_ext_data_hit: assert property (upd && $past(acc_valid) && !$past(acc_io_op) &&
      $past(cfg_ready_q) && !legacy_q && $past(acc_addr) == LCAM_EXT_LO |-> hit_ext_q)
    else $error("extended data access missed");
  chk_io_window: assert property (upd && $past(acc_valid) && $past(acc_io_op) &&
      $past(fuse_ok) |-> hit_io_q)
    else $error("in/out missed legacy window");
  chk_legacy_ram: assert property (legacy_q |-> !hit_ext_q && !hit_pchg_q && !hit_tmr2_q)
    else $error("peripheral active in legacy mode");
  chk_vec_count: assert property (cfg_ready_q |->
      vec_count_q == (legacy_q ? LCAM_VEC_LEGACY : LCAM_VEC_FULL))
    else $error("vector table size wrong");
  chk_gates_follow: assert property (cfg_ready_q |-> (wdt_timed_seq_en_q == !legacy_q) &&
      (rx_double_buf_en_q == !legacy_q) && (pchg_irq_en_q == !legacy_q))
    else $error("feature gate disagrees with mode");
  chk_tmr2_gate: assert property (legacy_q |-> !tmr2_en_q && !hit_tmr2_q)
    else $error("second wide timer reachable");
  chk_baud_fixed: assert property (upd && $past(acc_valid) && $past(fuse_ok) &&
      $past(acc_addr) == LCAM_BAUD1_ADDR && !$past(acc_io_op) |-> hit_baud1_q)
    else $error("baud high byte not decoded");
  chk_mode_stable: assert property (cfg_ready_q |=> $stable(legacy_q) && cfg_ready_q)
    else $error("mode changed while running");

  // Nothing decodes until the fuse has been captured
  chk_pre_ready_quiet: assert property (upd && !$past(fuse_ok) |->
      !hit_io_q && !hit_ext_q && !hit_ram_q && !hit_baud0_q &&
      !hit_baud1_q && !acc_write_q)
    else $error("decode before fuse capture");

  // An idle cycle must clear the io, ext, ram, pin-change, timer2 and write results
  chk_idle_clear: assert property (upd && !$past(acc_valid) |->
      !hit_io_q && !hit_ext_q && !hit_ram_q &&
      !hit_pchg_q && !hit_tmr2_q && !acc_write_q)
    else $error("access result outlived its cycle");

  // Legacy data access to the extended region must land in RAM
  chk_legacy_ram_hit: assert property (upd && $past(acc_valid) && !$past(acc_io_op) &&
      legacy_q && $past(cfg_ready_q) && $past(acc_addr) == LCAM_EXT_HI |-> hit_ram_q)
    else $error("legacy extended access missed RAM");

  // Legacy gates, one per feature
  chk_wdt_gate: assert property (legacy_q |-> !wdt_timed_seq_en_q)
    else $error("timed watchdog sequence active in legacy mode");
  chk_rx_single: assert property (legacy_q |-> !rx_double_buf_en_q)
    else $error("receive double buffer active in legacy mode");
  chk_pchg_gate: assert property (legacy_q |-> !pchg_irq_en_q && !hit_pchg_q)
    else $error("pin-change logic active in legacy mode");

  // Store flag follows the qualified access
  chk_write_copy: assert property (upd && $past(acc_valid) && $past(fuse_ok) |->
      acc_write_q == $past(acc_write))
    else $error("write flag lost");

  // First baud high byte decodes from a data access too
  chk_baud0_fixed: assert property (upd && $past(acc_valid) && $past(fuse_ok) &&
      $past(acc_addr) == LCAM_BAUD0_ADDR && !$past(acc_io_op) |-> hit_baud0_q)
    else $error("first baud high byte not decoded");

  // Main scenarios seen at least once
  cov_legacy: cover property (cfg_ready_q && legacy_q && hit_ram_q);
  cov_hold: cover property (!clk_en && hit_baud0_q);
  cov_full_ext: cover property (cfg_ready_q && !legacy_q && hit_pchg_q);
  cov_io_op: cover property (hit_io_q && hit_baud0_q);
endmodule

// ===== dv/lcam_addr_map_tb.sv
`timescale 1ns/100ps
module lcam_addr_map_tb
  import lcam_pkg::*;
;
  logic mclk;
  logic reset_n;
  logic clk_en;
  logic legacy_mode_fuse;
  logic acc_valid;
  logic acc_io_op;
  logic acc_write;
  logic [15:0] acc_addr;
  logic cfg_ready_q, legacy_q, hit_io_q, hit_ext_q, hit_ram_q, hit_baud0_q, hit_baud1_q;
  logic hit_pchg_q, hit_tmr2_q, acc_write_q, wdt_q, rxd_q, pcirq_q, tmr2_q;
  logic [7:0] periph_ofs_q;
  logic [4:0] vec_count_q;
  int error_cnt = 0;
  int num_checks = 0;

  // ==========================================================
  // Device and clock
  lcam_addr_map lcam_addr_map_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .legacy_mode_fuse(legacy_mode_fuse), .acc_valid(acc_valid), .acc_io_op(acc_io_op),
    .acc_write(acc_write), .acc_addr(acc_addr), .cfg_ready_q(cfg_ready_q),
    .legacy_q(legacy_q), .hit_io_q(hit_io_q), .hit_ext_q(hit_ext_q), .hit_ram_q(hit_ram_q),
    .hit_baud0_q(hit_baud0_q), .hit_baud1_q(hit_baud1_q), .hit_pchg_q(hit_pchg_q),
    .hit_tmr2_q(hit_tmr2_q), .acc_write_q(acc_write_q), .periph_ofs_q(periph_ofs_q),
    .vec_count_q(vec_count_q), .wdt_timed_seq_en_q(wdt_q), .rx_double_buf_en_q(rxd_q),
    .pchg_irq_en_q(pcirq_q), .tmr2_en_q(tmr2_q));

  // Half period of 20 ns gives 25 MHz
  always #20 mclk = ~mclk;

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Packed hits: write, io, ext, ram, baud0, baud1, pin-change, timer2
  function automatic logic [15:0] hits();
    return {8'h00, acc_write_q, hit_io_q, hit_ext_q, hit_ram_q, hit_baud0_q, hit_baud1_q,
      hit_pchg_q, hit_tmr2_q};
  endfunction

  // One access per enabled cycle, judged one cycle later
  task automatic acc(input logic io, input logic wr, input logic [15:0] a,
      input logic [7:0] exp_hits, input logic [7:0] exp_ofs);
    acc_valid = 1'b1;
    acc_io_op = io;
    acc_write = wr;
    acc_addr = a;
    @(negedge mclk);
    check(hits(), {8'h00, exp_hits});
    check({8'h00, periph_ofs_q}, {8'h00, exp_ofs});
  endtask

  // Idle cycle: every hit must drop after one cycle
  task automatic idle();
    acc_valid = 1'b0;
    @(negedge mclk);
    check(hits(), 16'h0000);
  endtask

  // ==========================================================
  // Scenarios
  task automatic start_up(input logic fuse);
    int n;
    n = 0;
    reset_n = 1'b0;
    legacy_mode_fuse = fuse;
    acc_valid = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    while (cfg_ready_q !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      conclude();
    end
    check({15'h0000, legacy_q}, {15'h0000, fuse});
    check({11'h000, vec_count_q}, {11'h000, fuse ? LCAM_VEC_LEGACY : LCAM_VEC_FULL});
    check({12'h000, wdt_q, rxd_q, pcirq_q, tmr2_q}, fuse ? 16'h0000 : 16'h000F);
  endtask

  // Region boundaries back to back, in/out folded into the legacy window
  task automatic full_map();
    acc(1'b0, 1'b0, 16'h0060, 8'h20, 8'h60);
    acc(1'b0, 1'b1, 16'h0061, 8'hA2, 8'h61);
    acc(1'b0, 1'b0, 16'h0088, 8'h21, 8'h88);
    acc(1'b0, 1'b0, 16'h00FF, 8'h20, 8'hFF);
    acc(1'b0, 1'b0, 16'h0100, 8'h00, 8'h00);
    acc(1'b0, 1'b0, 16'h001F, 8'h00, 8'h1F);
    acc(1'b0, 1'b0, 16'h005F, 8'h40, 8'h5F);
    acc(1'b1, 1'b0, 16'h0020, 8'h48, 8'h40);
    acc(1'b1, 1'b1, 16'h0060, 8'hC8, 8'h40);
    acc(1'b1, 1'b0, 16'h003C, 8'h44, 8'h5C);
    idle();
  endtask

  // A frozen clock enable must hold the last result
  task automatic hold_check();
    acc(1'b0, 1'b0, 16'h0040, 8'h48, 8'h40);
    clk_en = 1'b0;
    acc_addr = 16'h0088;
    @(negedge mclk);
    check(hits(), 16'h0048);
    clk_en = 1'b1;
    idle();
  endtask

  task automatic legacy_map();
    acc(1'b0, 1'b0, 16'h0061, 8'h10, 8'h61);
    acc(1'b0, 1'b0, 16'h0088, 8'h10, 8'h88);
    acc(1'b0, 1'b1, 16'h00FF, 8'h90, 8'hFF);
    acc(1'b0, 1'b0, 16'h0040, 8'h48, 8'h40);
    acc(1'b1, 1'b0, 16'h003C, 8'h44, 8'h5C);
    idle();
  endtask

  // Fuse pin moves while running; mode must not follow it
  task automatic fuse_held();
    legacy_mode_fuse = 1'b0;
    repeat (5) @(negedge mclk);
    check({15'h0000, legacy_q}, 16'h0001);
    acc(1'b0, 1'b0, 16'h0062, 8'h10, 8'h62);
    idle();
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    legacy_mode_fuse = 1'b0;
    acc_valid = 1'b0;
    acc_io_op = 1'b0;
    acc_write = 1'b0;
    acc_addr = 16'h0000;
    @(negedge mclk);
    start_up(1'b0);
    full_map();
    hold_check();
    start_up(1'b1);
    legacy_map();
    fuse_held();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
endmodule
